// ===== tb/mcpc_tester.sv
// Tester model for the preload pins: entry level, shift clock, data.
// Assumes reset is released before the first frame; sdo has a pull-up.
`timescale 1ns/1ps
module mcpc_tester (
	input wire logic clk_sys, // System clock
	input wire logic ser_oe, // Device pulls serial out low
	input wire logic ser_o, // Device serial out value
	output logic dev_clk, // Shift clock, still outside frames
	output logic ser_in, // Serial data to device
	output logic entry, // Elevated level on entry pin
	output logic sdo // Serial out line after pull-up
);
	assign sdo = ser_oe ? ser_o : 1'b1;
	initial begin
		dev_clk = 1'b0;
		ser_in = 1'b1;
		entry = 1'b0;
	end
	task automatic set_entry(input logic on);
		@(posedge clk_sys);
		entry <= on;
	endtask
	// Returns the bit shown before the rising shift edge
	task automatic shift(input logic b, output logic seen);
		@(posedge clk_sys);
		ser_in <= b;
		@(posedge clk_sys);
		seen = sdo;
		dev_clk <= 1'b1;
		@(posedge clk_sys);
		dev_clk <= 1'b0;
		ser_in <= ~b; // Never leave the last bit standing
	endtask
endmodule

// ===== tb/mcpc_top_bench.sv
// Self-checking bench: register bus cycles and preload frames.
// Assumes the tester model drives the preload pins.
`timescale 1ns/1ps
module mcpc_top_bench;
	import mcpc_pkg::*;
	logic clk_sys, resetn, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
	logic goe_n_pin, dev_clk, ser_in, entry, ser_o, ser_oe, sdo, seen;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [3:0] wb_sel_i;
	logic [3:0] pat;
	logic [1:0] aux_in;
	logic [7:0] func_in;
	mcpc_pins_t mc_pin;
	int miscompares, n_checks, cycles;
	mcpc_top mcpc_top_i (.clk_sys(clk_sys), .resetn(resetn),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
		.wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dev_clk_pin(dev_clk),
		.goe_n_pin(goe_n_pin), .preload_entry(entry), .ser_in(ser_in),
		.ser_out_o(ser_o), .ser_out_oe(ser_oe), .func_in(func_in),
		.mc_pin(mc_pin), .aux_in(aux_in));
	mcpc_tester mcpc_tester_i (.clk_sys(clk_sys), .ser_oe(ser_oe),
		.ser_o(ser_o), .dev_clk(dev_clk), .ser_in(ser_in),
		.entry(entry), .sdo(sdo));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic tally_and_finish();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic chk(input string what, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	initial begin
		resetn = 1'b0;
		{wb_we_i, wb_cyc_i, wb_stb_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'hf;
		goe_n_pin = 1'b0;
		func_in = 8'h00;
		pat = 4'hd;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		wb(0, ADDR_ARCH, 0); chk("arch", 32'h0000ff01, rd);
		wb(0, ADDR_MC_STATE, 0); chk("regs", 32'h0, rd);
		wb(1, ADDR_SIG_LO, 32'h13579bdf);
		wb(1, ADDR_SIG_HI, 32'h2468ace0);
		wb(0, ADDR_SIG_LO, 0); chk("siglo", 32'h13579bdf, rd);
		wb(0, ADDR_SIG_HI, 0); chk("sighi", 32'h2468ace0, rd);
		wb(0, 8'h14, 0); chk("unmapped", 32'h0, rd);
		wb(1, ADDR_ARCH, 32'h00005a02); // Cells 0 2 5 7 registered
		wb(0, ADDR_CTRL, 0); chk("ctrl", 32'h00000400, rd);
		mcpc_tester_i.set_entry(1'b1);
		wb(0, ADDR_CTRL, 0); chk("ctrl", 32'h00000404, rd);
		for (int i = 0; i < 8; i++) begin
			mcpc_tester_i.shift(pat[i % 4], seen);
			chk("sdo", (i < 4) ? 0 : pat[i % 4], seen);
		end
		wb(0, ADDR_MC_STATE, 0); chk("regs", 32'h85, rd);
		wb(1, ADDR_ARCH, 32'h0000ff02);
		repeat (2) mcpc_tester_i.shift(1'b0, seen);
		wb(0, ADDR_MC_STATE, 0); chk("regs", 32'h85, rd);
		mcpc_tester_i.set_entry(1'b0);
		func_in <= 8'h33;
		wb(1, ADDR_ARCH, 32'h00f05a02);
		@(posedge clk_sys);
		chk("oe", 8'ha5, mc_pin.oe & 8'ha5);
		chk("out", 8'h38, mc_pin.out);
		chk("aux", 0, aux_in);
		mcpc_tester_i.shift(1'b0, seen);
		wb(0, ADDR_MC_STATE, 0); chk("regs", 32'h81, rd);
		chk("out", 8'h3c, mc_pin.out);
		goe_n_pin <= 1'b1;
		@(posedge clk_sys);
		chk("oe", 8'h5a, mc_pin.oe);
		wb(1, ADDR_CTRL, 32'h2);
		wb(0, ADDR_ARCH, 0); chk("arch", 32'h0, rd);
		wb(1, ADDR_SIG_LO, 32'h0);
		wb(0, ADDR_SIG_LO, 0); chk("siglo", 32'h13579bdf, rd);
		wb(0, ADDR_CTRL, 0); chk("ctrl", 32'h00000402, rd);
		wb(1, ADDR_CTRL, 32'h1);
		wb(0, ADDR_ARCH, 0); chk("arch", 32'h0000ff01, rd);
		wb(0, ADDR_SIG_HI, 0); chk("sighi", 32'h0, rd);
		wb(0, ADDR_CTRL, 0); chk("ctrl", 32'h0, rd);
		chk("aux", 32'h2, aux_in);
		chk("oe", 8'h00, mc_pin.oe);
		tally_and_finish();
	end
endmodule

// ===== verilog/mcpc_arch.sv
// Decodes the architecture cells into per-macrocell path and pin drive.
// Assumes configuration and register state come from flip-flops.
`timescale 1ns/1ps
module mcpc_arch
	import mcpc_pkg::*;
(
	input wire mcpc_pkg::mcpc_cfg_t cfg, // Architecture cells
	input wire logic goe_n, // Global output enable pin, active low
	input wire logic [7:0] func_in, // Logic array results
	input wire logic [7:0] mc_q, // Macrocell registers
	output logic [7:0] reg_mask, // Macrocells in registered path
	output mcpc_pkg::mcpc_pins_t pins // Macrocell pin drive
);
	always_comb begin
		for (int i = 0; i < MCPC_N; i++) begin
			reg_mask[i] = ~cfg.reg_mode_sel & cfg.ag & ~cfg.path[i];
			if (!cfg.ag) begin
				pins.oe[i] = ~cfg.path[i];
			end else if (reg_mask[i]) begin
				pins.oe[i] = ~goe_n;
			end else begin
				pins.oe[i] = 1'b1;
			end
			// Register path shows the flop inverted; polarity sits ahead
			if (reg_mask[i]) begin
				pins.out[i] = ~mc_q[i];
			end else begin
				pins.out[i] = cfg.pol[i] ? func_in[i] : ~func_in[i];
			end
		end
	end
endmodule

// ===== verilog/mcpc_chain.sv
// Next state of the preload shift chain through registered macrocells.
// Assumes the caller applies the result only on a shift clock edge.
`timescale 1ns/1ps
module mcpc_chain
	import mcpc_pkg::*;
(
	input wire logic [7:0] reg_mask, // Registered macrocells
	input wire logic [7:0] mc_q, // Present register contents
	input wire logic ser_in, // Serial data in
	output logic [7:0] mc_nxt, // Contents after one shift
	output logic ser_bit, // Bit leaving the chain
	output logic [3:0] chain_len // Number of stages
);
	logic carry;

	always_comb begin
		carry = ser_in;
		chain_len = 4'h0;
		mc_nxt = mc_q;
		// Lowest index is the lowest pin number: data walks upward
		for (int i = 0; i < MCPC_N; i++) begin
			if (reg_mask[i]) begin
				mc_nxt[i] = carry;
				carry = mc_q[i];
				chain_len = chain_len + 4'h1;
			end
		end
		ser_bit = carry;
	end
endmodule

// ===== verilog/mcpc_pkg.sv
// Package for the macrocell configuration and preload chain block.
// Assumes a single 25 MHz system clock and a classic Wishbone master.
package mcpc_pkg;
	localparam int MCPC_N = 8;
	localparam int MCPC_SIG_W = 64;
	localparam int MCPC_CNT_W = 4;

	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ARCH = 8'h04;
	localparam logic [7:0] ADDR_SIG_LO = 8'h08;
	localparam logic [7:0] ADDR_SIG_HI = 8'h0c;
	localparam logic [7:0] ADDR_MC_STATE = 8'h10;

	// Field positions
	localparam int CTRL_ERASE_BIT = 0;
	localparam int CTRL_SECURE_BIT = 1;
	localparam int CTRL_PRELOAD_BIT = 2;
	localparam int CTRL_LEN_LSB = 8;
	localparam int ARCH_REG_MODE_BIT = 0;
	localparam int ARCH_AG_BIT = 1;
	localparam int ARCH_PATH_LSB = 8;
	localparam int ARCH_POL_LSB = 16;

	// Erased (unprogrammed) and reset values
	localparam logic ERASED_REG_MODE = 1'b1;
	localparam logic ERASED_AG = 1'b0;
	localparam logic [7:0] ERASED_PATH = 8'hff;
	localparam logic [7:0] ERASED_POL = 8'h00;
	localparam logic [63:0] ERASED_SIG = 64'h0;
	localparam logic [7:0] MC_RESET = 8'h00;

	typedef struct packed {
		logic reg_mode_sel;
		logic ag;
		logic [7:0] path;
		logic [7:0] pol;
	} mcpc_cfg_t;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} mcpc_pins_t;

	typedef enum logic [1:0] {
		MCPC_IDLE = 2'b01,
		MCPC_ACK = 2'b10
	} mcpc_bus_st_t;
endpackage

// ===== verilog/mcpc_top.sv
// Macrocell configuration, signature, erase and register preload chain.
// Assumes a classic Wishbone master and pins synchronous to clk_sys.
// Function
// - Hold a 64-bit user signature word
// - Signature never affects logic behaviour
// - Signature readable even when secured
// - Bulk erase clears cells, security and signature
// - Preload loads registers and shows their state
// - Preload only while entry input elevated
// - One chain stage per registered macrocell
// - Shift on rising shift clock edge
// - Data enters lowest pin, moves upward
// - Old contents shift out serially
// - Low means 0; normal output inverted
// - Serial output is open drain in preload
// - Two global cells, two per macrocell
// - Registered select chooses clock/enable pins
// - Small mode: path cell picks output/input
// - Registered mode: path cell picks register/combinational
// - Polarity cell: 0 active low, 1 high
// - Registers cleared low at power-up
// - Security blocks programming and verify until erase
// - Global enable gates registered outputs only
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module mcpc_top
	import mcpc_pkg::*;
(
	input wire logic clk_sys, // 25 MHz system clock
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic [7:0] wb_adr_i, // Wishbone byte address
	input wire logic [31:0] wb_dat_i, // Wishbone write data
	input wire logic [3:0] wb_sel_i, // Wishbone byte lane selects
	input wire logic wb_we_i, // Wishbone write enable
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	output logic [31:0] wb_dat_o, // Wishbone read data
	output logic wb_ack_o, // Wishbone acknowledge
	input wire logic dev_clk_pin, // Device clock / shift clock pin
	input wire logic goe_n_pin, // Global output enable pin, active low
	input wire logic preload_entry, // Elevated voltage seen on entry pin
	input wire logic ser_in, // Preload serial data in
	output logic ser_out_o, // Preload serial out, output value
	output logic ser_out_oe, // Preload serial out, output enable
	input wire logic [7:0] func_in, // Logic array results per macrocell
	output mcpc_pkg::mcpc_pins_t mc_pin, // Macrocell pin drive
	output logic [1:0] aux_in // Clock and enable pins as plain inputs
);
	import mcpc_pkg::*;

	mcpc_bus_st_t st_q, st_d;
	logic [31:0] rdat_q, rdat_d;
	mcpc_cfg_t cfg_q, cfg_d;
	logic [63:0] sig_q, sig_d;
	logic secure_q, secure_d;
	logic [7:0] mc_q, mc_d;
	logic clkp_q, clkp_d;
	logic [7:0] reg_mask;
	logic [7:0] mc_nxt;
	logic ser_bit;
	logic [3:0] chain_len;
	logic req, wr, clk_rise, any_reg, in_preload;
	logic erase_req;
	mcpc_cfg_t erased_cfg;

	// Applies Wishbone byte selects to a stored word
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	assign erased_cfg = '{reg_mode_sel: ERASED_REG_MODE, ag: ERASED_AG,
		path: ERASED_PATH, pol: ERASED_POL};

	mcpc_arch mcpc_arch_i (
		.cfg(cfg_q),
		.goe_n(goe_n_pin),
		.func_in(func_in),
		.mc_q(mc_q),
		.reg_mask(reg_mask),
		.pins(mc_pin)
	);

	mcpc_chain mcpc_chain_i (
		.reg_mask(reg_mask),
		.mc_q(mc_q),
		.ser_in(ser_in),
		.mc_nxt(mc_nxt),
		.ser_bit(ser_bit),
		.chain_len(chain_len)
	);

	// Bus handshake state
	assign req = wb_cyc_i & wb_stb_i & (st_q == MCPC_IDLE);
	assign wr = req & wb_we_i;
	assign wb_ack_o = (st_q == MCPC_ACK);
	assign wb_dat_o = rdat_q;
	assign erase_req = wr & (wb_adr_i == ADDR_CTRL) & wb_sel_i[0]
		& wb_dat_i[CTRL_ERASE_BIT];

	always_comb begin
		st_d = st_q;
		case (st_q)
			MCPC_IDLE: begin
				if (req) begin
					st_d = MCPC_ACK;
				end
			end
			MCPC_ACK: begin
				st_d = MCPC_IDLE;
			end
			default: begin
				st_d = MCPC_IDLE;
			end
		endcase
	end

	// Read data; unmapped offsets answer with zero
	always_comb begin
		rdat_d = rdat_q;
		if (req && !wb_we_i) begin
			rdat_d = 32'h0;
			if (wb_adr_i == ADDR_CTRL) begin
				rdat_d[CTRL_SECURE_BIT] = secure_q;
				rdat_d[CTRL_PRELOAD_BIT] = in_preload;
				rdat_d[CTRL_LEN_LSB +: 4] = chain_len;
			end else if (wb_adr_i == ADDR_ARCH) begin
				// Verify path shows nothing once secured
				if (!secure_q) begin
					rdat_d[ARCH_REG_MODE_BIT] = cfg_q.reg_mode_sel;
					rdat_d[ARCH_AG_BIT] = cfg_q.ag;
					rdat_d[ARCH_PATH_LSB +: 8] = cfg_q.path;
					rdat_d[ARCH_POL_LSB +: 8] = cfg_q.pol;
				end
			end else if (wb_adr_i == ADDR_SIG_LO) begin
				rdat_d = sig_q[31:0];
			end else if (wb_adr_i == ADDR_SIG_HI) begin
				rdat_d = sig_q[63:32];
			end else if (wb_adr_i == ADDR_MC_STATE) begin
				rdat_d[7:0] = mc_q;
			end
		end
	end

	// Programmable cells: erase always works, programming only unsecured
	always_comb begin
		logic [31:0] w;
		w = 32'h0;
		cfg_d = cfg_q;
		sig_d = sig_q;
		secure_d = secure_q;
		if (erase_req) begin
			cfg_d = erased_cfg;
			sig_d = ERASED_SIG;
			secure_d = 1'b0;
		end else if (wr && !secure_q) begin
			if (wb_adr_i == ADDR_CTRL) begin
				if (wb_sel_i[0] && wb_dat_i[CTRL_SECURE_BIT]) begin
					secure_d = 1'b1;
				end
			end else if (wb_adr_i == ADDR_ARCH) begin
				w = {8'h0, cfg_q.pol, cfg_q.path, 6'h0, cfg_q.ag,
					cfg_q.reg_mode_sel};
				w = lane_merge(w, wb_dat_i, wb_sel_i);
				cfg_d.reg_mode_sel = w[ARCH_REG_MODE_BIT];
				cfg_d.ag = w[ARCH_AG_BIT];
				cfg_d.path = w[ARCH_PATH_LSB +: 8];
				cfg_d.pol = w[ARCH_POL_LSB +: 8];
			end else if (wb_adr_i == ADDR_SIG_LO) begin
				sig_d[31:0] = lane_merge(sig_q[31:0], wb_dat_i, wb_sel_i);
			end else if (wb_adr_i == ADDR_SIG_HI) begin
				sig_d[63:32] = lane_merge(sig_q[63:32], wb_dat_i,
					wb_sel_i);
			end
		end
	end

	// Pin 1 is the register clock when registers are allowed; the
	// signature feeds nothing on this path
	assign clk_rise = dev_clk_pin & ~clkp_q;
	assign any_reg = |reg_mask;
	assign in_preload = preload_entry & ~cfg_q.reg_mode_sel;
	assign aux_in = cfg_q.reg_mode_sel ? {goe_n_pin, dev_clk_pin} : 2'b00;

	always_comb begin
		clkp_d = dev_clk_pin;
		mc_d = mc_q;
		if (in_preload) begin
			if (clk_rise && any_reg) begin
				mc_d = mc_nxt;
			end
		end else if (clk_rise) begin
			for (int i = 0; i < MCPC_N; i++) begin
				if (reg_mask[i]) begin
					// Polarity applied ahead of the register
					mc_d[i] = func_in[i] ^ cfg_q.pol[i];
				end
			end
		end
	end

	// Open drain: only ever pulls low, a pull-up supplies the high
	assign ser_out_o = 1'b0;
	assign ser_out_oe = in_preload & any_reg & ~ser_bit;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_q <= MCPC_IDLE;
			rdat_q <= 32'h0;
			cfg_q <= '{reg_mode_sel: ERASED_REG_MODE, ag: ERASED_AG,
				path: ERASED_PATH, pol: ERASED_POL};
			sig_q <= ERASED_SIG;
			secure_q <= 1'b0;
			mc_q <= MC_RESET;
			clkp_q <= 1'b0;
		end else begin
			st_q <= st_d;
			rdat_q <= rdat_d;
			cfg_q <= cfg_d;
			sig_q <= sig_d;
			secure_q <= secure_d;
			mc_q <= mc_d;
			clkp_q <= clkp_d;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	req_answer_a: assert property (req |=> wb_ack_o)
		else $error("request not answered in one cycle");

	erase_clears_a: assert property (erase_req |=>
		(cfg_q == erased_cfg) && !secure_q && (sig_q == ERASED_SIG))
		else $error("bulk erase left programmed state");

	secure_block_a: assert property (secure_q && wr && !erase_req |=>
		$stable(cfg_q) && $stable(sig_q))
		else $error("secured device accepted programming");

	sig_read_a: assert property (wb_ack_o && !wb_we_i &&
		wb_adr_i == ADDR_SIG_HI |-> wb_dat_o == sig_q[63:32])
		else $error("signature read wrong");

	shift_step_a: assert property (in_preload && clk_rise && any_reg
		|=> mc_q == $past(mc_nxt) && (mc_q & ~reg_mask) ==
		($past(mc_q) & ~reg_mask))
		else $error("preload shift wrong");

	empty_chain_a: assert property (in_preload && !any_reg
		|=> $stable(mc_q))
		else $error("empty chain altered registers");

	open_drain_a: assert property (ser_out_oe |->
		!ser_out_o && preload_entry)
		else $error("serial out drove high or outside preload");

	reset_clear_a: assert property (!$past(resetn) |-> mc_q == MC_RESET)
		else $error("registers not cleared after reset");

	small_mode_a: assert property (!cfg_q.ag |->
		mc_pin.oe == ~cfg_q.path)
		else $error("small mode pin direction wrong");

	reg_out_a: assert property ((mc_pin.out & reg_mask) ==
		(~mc_q & reg_mask))
		else $error("registered output not inverted");

	sig_lo_read_a: assert property (wb_ack_o && !wb_we_i &&
		wb_adr_i == ADDR_SIG_LO |-> wb_dat_o == sig_q[31:0])
		else $error("signature low read wrong");

	arch_hidden_a: assert property (wb_ack_o && !wb_we_i &&
		wb_adr_i == ADDR_ARCH && secure_q |-> wb_dat_o == 32'h0)
		else $error("secured device showed architecture");

	secure_set_a: assert property (wr && !erase_req &&
		wb_adr_i == ADDR_CTRL && wb_sel_i[0] &&
		wb_dat_i[CTRL_SECURE_BIT] |=> secure_q)
		else $error("security request not taken");

	sig_write_a: assert property (wr && !secure_q && !erase_req &&
		wb_adr_i == ADDR_SIG_HI && wb_sel_i == 4'hf
		|=> sig_q[63:32] == $past(wb_dat_i))
		else $error("signature write lost");

	// A write answer must not disturb the last read word
	write_dat_hold_a: assert property (wb_ack_o && wb_we_i |->
		$stable(wb_dat_o))
		else $error("read data changed on a write");

	mc_hold_a: assert property (!clk_rise |=> $stable(mc_q))
		else $error("registers moved without a clock rise");

	normal_load_a: assert property (!in_preload && clk_rise
		|=> ((mc_q ^ $past(func_in ^ cfg_q.pol)) & $past(reg_mask))
		== 8'h00)
		else $error("registered cell loaded wrong value");

	comb_polarity_a: assert property (
		((mc_pin.out ^ ~(func_in ^ cfg_q.pol)) & ~reg_mask) == 8'h00)
		else $error("combinational polarity wrong");

	goe_reg_a: assert property (cfg_q.ag |->
		(mc_pin.oe & reg_mask) == ({8{~goe_n_pin}} & reg_mask))
		else $error("registered enable not from enable pin");

	goe_other_a: assert property (cfg_q.ag |->
		(mc_pin.oe | reg_mask) == 8'hff)
		else $error("enable pin reached a non-registered cell");

	aux_plain_a: assert property (cfg_q.reg_mode_sel |->
		aux_in == {goe_n_pin, dev_clk_pin})
		else $error("plain input pins not passed");

	aux_dedicated_a: assert property (!cfg_q.reg_mode_sel |->
		aux_in == 2'b00)
		else $error("clock and enable pins seen as inputs");

	chain_len_a: assert property (chain_len ==
		4'($countones(reg_mask)))
		else $error("chain length differs from registered cells");

	no_reg_a: assert property (cfg_q.reg_mode_sel || !cfg_q.ag |->
		reg_mask == 8'h00)
		else $error("registered cell outside registered mode");

	oe_outside_a: assert property (!in_preload |-> !ser_out_oe)
		else $error("serial out pulled outside preload");

	reset_inputs_a: assert property (!$past(resetn) |->
		mc_pin.oe == 8'h00)
		else $error("pins driven after reset");
endmodule
